// File: hdl/counter_pkg.sv
// constants, field layout and carrier types of the encoder counter core
// Functional notes
// - hysteresis setting 0..255, 0 and 1 disable
// - hysteresis applies to compare and flow evaluation
// - output held for programmed pulse duration
// - pulse programmable in 2.048ms steps to 522.24ms
// - zero pulse: output follows compare condition
// - load starts count, end bounds the range
// - no direction: full signed 32-bit range
// - forward: at end-1 next pulse reloads load
// - backward: at end+1 next pulse reloads load
// - with hardware gate, abort/resume follows hardware edges
// - abort: reopen restarts from load value
// - interrupt: reopen resumes from last count
// - endless starts at load, full range limits
// - endless: up at maximum wraps to minimum
// - endless: down at minimum wraps to maximum
// - sticky overflow/underflow flags until status clear
// - once undirected: wrap and close gate
// - halted gate needs rising gate edge; resume keeps count
// - once with abort: reopen restarts from load
// - once forward: at end-1 reload, close, event
// - once backward: at end+1 reload, close, event
// - once directed: reopen counts from load value
// - periodic undirected: limit reloads load, event
// - six-bit one-hot function select, zero endless
// - gate is soft AND hard; soft gate edge-driven
package counter_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LOAD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_END = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CMP = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_HYST = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PULSE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;

  // control register fields
  localparam int FCT_LSB = 0;
  localparam int FCT_W = 6;
  localparam int HARD_GATE_EN_BIT = 8;
  localparam int GATE_RESUME_BIT = 9;
  localparam int OUT_MODE_LSB = 16;
  localparam int OUT_MODE_W = 3;
  localparam int EVT_EN_OVF_BIT = 24;
  localparam int EVT_EN_UNF_BIT = 25;
  localparam int EVT_EN_END_BIT = 26;

  // command register bits, each acts on its rising edge
  localparam int CMD_OPEN_BIT = 0;
  localparam int CMD_CLOSE_BIT = 1;
  localparam int CMD_CLEAR_BIT = 2;

  // status register bits
  localparam int ST_GATE_BIT = 0;
  localparam int ST_SOFT_BIT = 1;
  localparam int ST_OVF_BIT = 2;
  localparam int ST_UNF_BIT = 3;
  localparam int ST_OUT_BIT = 4;
  localparam int ST_HALT_BIT = 5;

  localparam logic [5:0] FCT_ENDLESS = 6'h00;
  localparam logic [5:0] FCT_ONCE_FWD = 6'h01;
  localparam logic [5:0] FCT_ONCE_BWD = 6'h02;
  localparam logic [5:0] FCT_ONCE_NONE = 6'h04;
  localparam logic [5:0] FCT_PER_FWD = 6'h08;
  localparam logic [5:0] FCT_PER_BWD = 6'h10;
  localparam logic [5:0] FCT_PER_NONE = 6'h20;

  localparam logic [2:0] OUT_NEVER = 3'h0;
  localparam logic [2:0] OUT_GE = 3'h1;
  localparam logic [2:0] OUT_LE = 3'h2;
  localparam logic [2:0] OUT_EQ = 3'h4;

  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] LOAD_RST = 32'h00000000;
  localparam logic [31:0] END_RST = 32'h00000000;
  localparam logic [31:0] CMP_RST = 32'h00000000;
  localparam logic [7:0] HYST_RST = 8'h00;
  localparam logic [7:0] PULSE_RST = 8'h00;
  localparam logic [31:0] COUNT_RST = 32'h00000000;

  localparam logic [31:0] COUNT_MAX = 32'h7fffffff;
  localparam logic [31:0] COUNT_MIN = 32'h80000000;
  localparam logic [7:0] HYST_MIN_ACTIVE = 8'h02;

  localparam int CLK_PERIOD_NS = 100;
  localparam int PULSE_STEP_NS = 2048000;
  localparam int PULSE_MAX_NS = 522240000;
  localparam int PULSE_TICK_CYCLES = PULSE_STEP_NS / CLK_PERIOD_NS;
  localparam int PULSE_MAX_STEPS = PULSE_MAX_NS / PULSE_STEP_NS;

  typedef enum logic [2:0] {
    G_CLOSED = 3'b001,
    G_OPEN = 3'b010,
    G_HALTED = 3'b100
  } gate_st_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic up;
    logic down;
  } enc_pulse_s;

  typedef struct packed {
    logic overflow;
    logic underflow;
    logic end_reached;
  } event_s;

endpackage

// File: hdl/counter_core.sv
// signed 32-bit encoder counter with gate, range functions, flags and compare output
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module counter_core
  import counter_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = PULSE_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire bus_req_s bus_req,
  output logic [DATA_W-1:0] rdata,
  input wire enc_pulse_s enc,
  input wire logic hard_gate,
  output logic compare_out,
  output logic overflow_flag,
  output logic underflow_flag,
  output logic gate_open,
  output logic [31:0] count_value,
  output event_s events
);

  typedef struct packed {
    logic [1:0] hard_sync;
    logic hard_prev;
    logic [31:0] ctrl;
    logic [31:0] load;
    logic [31:0] end_val;
    logic [31:0] cmp;
    logic [7:0] hyst;
    logic [7:0] pulse;
    logic [2:0] cmd;
    logic [2:0] cmd_prev;
    logic soft_gate;
    gate_st_e gate;
    logic fresh;
    logic [31:0] count;
    logic ovf;
    logic unf;
    logic flow_armed;
    logic cmp_hold;
    logic cond_prev;
    logic out;
    logic [7:0] pulse_left;
    logic [31:0] tick_cnt;
    event_s evt;
    logic [DATA_W-1:0] rdata;
  } state_s;

  localparam state_s ST_RESET = '{
    hard_sync: 2'h0,
    hard_prev: 1'b0,
    ctrl: CTRL_RST,
    load: LOAD_RST,
    end_val: END_RST,
    cmp: CMP_RST,
    hyst: HYST_RST,
    pulse: PULSE_RST,
    cmd: 3'h0,
    cmd_prev: 3'h0,
    soft_gate: 1'b0,
    gate: G_CLOSED,
    fresh: 1'b1,
    count: COUNT_RST,
    ovf: 1'b0,
    unf: 1'b0,
    flow_armed: 1'b1,
    cmp_hold: 1'b0,
    cond_prev: 1'b0,
    out: 1'b0,
    pulse_left: 8'h00,
    tick_cnt: 32'h00000000,
    evt: 3'h0,
    rdata: 32'h00000000
  };

  state_s s;
  state_s n;

  always_comb begin
    logic [5:0] fct;
    logic hw_en;
    logic resume;
    logic hyst_on;
    logic hard_eff;
    logic hard_rise;
    logic open_rise;
    logic close_rise;
    logic clear_rise;
    logic reopen;
    logic reload;
    logic is_once;
    logic is_per;
    logic is_fwd;
    logic is_bwd;
    logic is_none;
    logic up;
    logic dn;
    logic end_hit;
    logic ovf_hit;
    logic unf_hit;
    logic tick;
    logic flow_ok;
    logic [2:0] out_mode;
    logic signed [32:0] cnt_x;
    logic signed [32:0] cmp_x;
    logic signed [32:0] hyst_x;
    logic raw;
    logic held;
    logic cond;
    logic [31:0] flow_lo;
    logic [31:0] flow_hi;
    fct = s.ctrl[FCT_LSB +: FCT_W];
    hw_en = s.ctrl[HARD_GATE_EN_BIT];
    resume = s.ctrl[GATE_RESUME_BIT];
    out_mode = s.ctrl[OUT_MODE_LSB +: OUT_MODE_W];
    hyst_on = s.hyst >= HYST_MIN_ACTIVE;
    hard_eff = ~hw_en | s.hard_sync[1];
    hard_rise = s.hard_sync[1] & ~s.hard_prev;
    open_rise = s.cmd[CMD_OPEN_BIT] & ~s.cmd_prev[CMD_OPEN_BIT];
    close_rise = s.cmd[CMD_CLOSE_BIT] & ~s.cmd_prev[CMD_CLOSE_BIT];
    clear_rise = s.cmd[CMD_CLEAR_BIT] & ~s.cmd_prev[CMD_CLEAR_BIT];
    // unknown codes fall back to endless counting
    is_fwd = (fct == FCT_ONCE_FWD) | (fct == FCT_PER_FWD);
    is_bwd = (fct == FCT_ONCE_BWD) | (fct == FCT_PER_BWD);
    is_once = (fct == FCT_ONCE_FWD) | (fct == FCT_ONCE_BWD) | (fct == FCT_ONCE_NONE);
    is_per = (fct == FCT_PER_FWD) | (fct == FCT_PER_BWD) | (fct == FCT_PER_NONE);
    is_none = ~is_fwd & ~is_bwd;
    up = enc.up & ~enc.down;
    dn = enc.down & ~enc.up;
    end_hit = 1'b0;
    ovf_hit = 1'b0;
    unf_hit = 1'b0;
    reload = 1'b0;
    reopen = open_rise | (hw_en & hard_rise);
    tick = s.tick_cnt == 32'(TICK_CYCLES - 1);
    flow_ok = 1'b1;

    n = s;
    n.evt = '0;
    n.rdata = '0;
    n.hard_sync = {s.hard_sync[0], hard_gate};
    n.hard_prev = s.hard_sync[1];
    n.cmd_prev = s.cmd;

    if (bus_req.wr) begin
      case (bus_req.addr)
        OFS_CTRL: n.ctrl = bus_req.wdata;
        OFS_LOAD: n.load = bus_req.wdata;
        OFS_END: n.end_val = bus_req.wdata;
        OFS_CMP: n.cmp = bus_req.wdata;
        OFS_HYST: n.hyst = bus_req.wdata[7:0];
        OFS_PULSE: n.pulse = bus_req.wdata[7:0];
        OFS_CMD: n.cmd = bus_req.wdata[2:0];
        default: ;
      endcase
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_CTRL: n.rdata = s.ctrl;
        OFS_LOAD: n.rdata = s.load;
        OFS_END: n.rdata = s.end_val;
        OFS_CMP: n.rdata = s.cmp;
        OFS_HYST: n.rdata = {24'h000000, s.hyst};
        OFS_PULSE: n.rdata = {24'h000000, s.pulse};
        OFS_CMD: n.rdata = {29'h00000000, s.cmd};
        OFS_COUNT: n.rdata = s.count;
        OFS_STATUS: begin
          n.rdata[ST_GATE_BIT] = s.gate == G_OPEN;
          n.rdata[ST_SOFT_BIT] = s.soft_gate;
          n.rdata[ST_OVF_BIT] = s.ovf;
          n.rdata[ST_UNF_BIT] = s.unf;
          n.rdata[ST_OUT_BIT] = s.out;
          n.rdata[ST_HALT_BIT] = s.gate == G_HALTED;
        end
        default: n.rdata = '0;
      endcase
    end

    if (close_rise) begin
      n.soft_gate = 1'b0;
    end else if (open_rise) begin
      n.soft_gate = 1'b1;
    end

    case (s.gate)
      G_CLOSED: begin
        if (s.soft_gate & hard_eff) begin
          n.gate = G_OPEN;
          // with the hardware gate in use only its edge may abort
          reload = s.fresh | (~resume & (~hw_en | hard_rise));
        end
      end
      G_OPEN: begin
        if (~(s.soft_gate & hard_eff)) begin
          n.gate = G_CLOSED;
        end else if (up) begin
          if (is_fwd && s.count == s.end_val - 32'h00000001) begin
            n.count = s.load;
            end_hit = 1'b1;
          end else if (s.count == COUNT_MAX) begin
            ovf_hit = 1'b1;
            n.count = is_per ? s.load : COUNT_MIN;
            if (is_once & is_none) begin
              n.gate = G_HALTED;
            end
          end else begin
            n.count = s.count + 32'h00000001;
          end
        end else if (dn) begin
          if (is_bwd && s.count == s.end_val + 32'h00000001) begin
            n.count = s.load;
            end_hit = 1'b1;
          end else if (s.count == COUNT_MIN) begin
            unf_hit = 1'b1;
            n.count = is_per ? s.load : COUNT_MAX;
            if (is_once & is_none) begin
              n.gate = G_HALTED;
            end
          end else begin
            n.count = s.count - 32'h00000001;
          end
        end
        if (end_hit & is_once) begin
          n.gate = G_HALTED;
        end
      end
      G_HALTED: begin
        if (~s.soft_gate) begin
          n.gate = G_CLOSED;
        end else if (reopen & hard_eff) begin
          n.gate = G_OPEN;
          // directed once-mode already reloaded at the end value
          reload = ~resume & (~hw_en | hard_rise);
        end
      end
      default: n.gate = G_CLOSED;
    endcase

    if (reload) begin
      n.count = s.load;
      n.fresh = 1'b0;
    end else if (n.gate == G_OPEN) begin
      n.fresh = 1'b0;
    end

    // flow events are suppressed until the count leaves the wrap zone
    flow_lo = COUNT_MIN + {24'h000000, s.hyst};
    flow_hi = COUNT_MAX - {24'h000000, s.hyst};
    // re-arm only once the count is well clear of both limits
    if (~s.flow_armed
        && $signed(s.count) >= $signed(flow_lo)
        && $signed(s.count) <= $signed(flow_hi)) begin
      n.flow_armed = 1'b1;
    end
    if (ovf_hit | unf_hit) begin
      if (hyst_on) begin
        n.flow_armed = 1'b0;
      end
      // a jitter back across the wrap must not flag a second flow
      flow_ok = ~hyst_on | s.flow_armed;
    end
    ovf_hit = ovf_hit & flow_ok;
    unf_hit = unf_hit & flow_ok;
    // set wins over a clear in the same cycle
    n.ovf = (s.ovf & ~clear_rise) | ovf_hit;
    n.unf = (s.unf & ~clear_rise) | unf_hit;
    n.evt.overflow = ovf_hit & s.ctrl[EVT_EN_OVF_BIT];
    n.evt.underflow = unf_hit & s.ctrl[EVT_EN_UNF_BIT];
    // periodic undirected wraps count as reaching the end of a period
    n.evt.end_reached = (end_hit | (is_per & is_none & (ovf_hit | unf_hit)))
                        & s.ctrl[EVT_EN_END_BIT];

    // compare in 33 bits so threshold offsets cannot wrap
    cnt_x = $signed({s.count[31], s.count});
    cmp_x = $signed({s.cmp[31], s.cmp});
    hyst_x = $signed({25'h0000000, s.hyst});
    case (out_mode)
      OUT_GE: begin
        raw = cnt_x >= cmp_x;
        held = cnt_x > cmp_x - hyst_x;
      end
      OUT_LE: begin
        raw = cnt_x <= cmp_x;
        held = cnt_x < cmp_x + hyst_x;
      end
      OUT_EQ: begin
        raw = cnt_x == cmp_x;
        held = (cnt_x > cmp_x - hyst_x) && (cnt_x < cmp_x + hyst_x);
      end
      default: begin
        raw = 1'b0;
        held = 1'b0;
      end
    endcase
    cond = raw | (hyst_on & s.cmp_hold & held);
    n.cmp_hold = cond;
    n.cond_prev = cond;

    // free-running timebase; pulse length is accurate to one step
    n.tick_cnt = tick ? 32'h00000000 : s.tick_cnt + 32'h00000001;
    if (s.pulse == 8'h00) begin
      n.pulse_left = 8'h00;
      n.out = cond;
    end else begin
      if (s.pulse_left != 8'h00) begin
        // no retrigger while a pulse is running
        if (tick) begin
          n.pulse_left = s.pulse_left - 8'h01;
        end
      end else if (cond & ~s.cond_prev) begin
        n.pulse_left = s.pulse;
      end
      n.out = n.pulse_left != 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= ST_RESET;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign compare_out = s.out;
  assign overflow_flag = s.ovf;
  assign underflow_flag = s.unf;
  assign gate_open = s.gate == G_OPEN;
  assign count_value = s.count;
  assign events = s.evt;

endmodule

// File: test/counter_core_checker.sv
// port-level assertions for the encoder counter core
`timescale 1ns/1ps
module counter_core_checker
  import counter_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = PULSE_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire bus_req_s bus_req,
  input wire logic [DATA_W-1:0] rdata,
  input wire enc_pulse_s enc,
  input wire logic hard_gate,
  input wire logic compare_out,
  input wire logic overflow_flag,
  input wire logic underflow_flag,
  input wire logic gate_open,
  input wire logic [31:0] count_value,
  input wire event_s events
);
  logic [31:0] ctrl;
  logic [31:0] load;
  logic [31:0] endv;
  logic [7:0] hyst;
  logic [2:0] cmd_hist;
  logic cmd_wr;
  logic endless;
  logic up1;
  logic dn1;
  assign cmd_wr = bus_req.wr && bus_req.addr == OFS_CMD;
  assign endless = ctrl[5:0] == FCT_ENDLESS;
  assign up1 = gate_open && enc.up && !enc.down;
  assign dn1 = gate_open && enc.down && !enc.up;
  // shadows of the written setup so expectations follow software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
      load <= LOAD_RST;
      endv <= END_RST;
      hyst <= HYST_RST;
      cmd_hist <= 3'h0;
    end else begin
      cmd_hist <= {cmd_hist[1:0], cmd_wr};
      if (bus_req.wr && bus_req.addr == OFS_CTRL) ctrl <= bus_req.wdata;
      if (bus_req.wr && bus_req.addr == OFS_LOAD) load <= bus_req.wdata;
      if (bus_req.wr && bus_req.addr == OFS_END) endv <= bus_req.wdata;
      if (bus_req.wr && bus_req.addr == OFS_HYST) hyst <= bus_req.wdata[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!bus_req.rd |=> rdata == 32'h0)
    else $error("read data not zero outside read answer");
  a_closed_hold: assert property ((!gate_open ##1 !gate_open) |-> $stable(count_value))
    else $error("count moved with gate closed");
  a_up_step: assert property (endless && up1 && count_value != COUNT_MAX
    |=> count_value == $past(count_value) + 32'h1)
    else $error("count did not step up by one");
  a_wrap_max: assert property (endless && up1 && count_value == COUNT_MAX
    |=> count_value == COUNT_MIN ##[0:1] overflow_flag)
    else $error("no wrap to minimum with overflow flag");
  a_wrap_min: assert property (endless && dn1 && count_value == COUNT_MIN
    |=> count_value == COUNT_MAX ##[0:1] underflow_flag)
    else $error("no wrap to maximum with underflow flag");
  a_ovf_sticky: assert property (overflow_flag && cmd_hist == 3'h0 && !cmd_wr |=> overflow_flag)
    else $error("overflow flag dropped without clear");
  a_unf_sticky: assert property (underflow_flag && cmd_hist == 3'h0 && !cmd_wr |=> underflow_flag)
    else $error("underflow flag dropped without clear");
  a_once_end: assert property (ctrl[5:0] == FCT_ONCE_FWD && up1 && count_value == endv - 32'h1
    |=> count_value == load && !gate_open)
    else $error("once forward end not reloaded and closed");
  a_once_back: assert property (ctrl[5:0] == FCT_ONCE_BWD && dn1 && count_value == endv + 32'h1
    |=> count_value == load && !gate_open)
    else $error("once backward end not reloaded and closed");
  a_ovf_event: assert property (endless && up1 && count_value == COUNT_MAX && hyst < HYST_MIN_ACTIVE
    && ctrl[EVT_EN_OVF_BIT] |=> events.overflow)
    else $error("overflow event missing");
  a_end_event: assert property (ctrl[5:0] == FCT_ONCE_FWD && ctrl[EVT_EN_END_BIT] && up1
    && count_value == endv - 32'h1 |=> events.end_reached)
    else $error("end event missing");
endmodule

// File: test/encoder_model.sv
// encoder pulse source and hardware gate line facing the counter core
`timescale 1ns/1ps
module encoder_model
  import counter_pkg::*;
(
  input wire logic clk,
  output enc_pulse_s enc,
  output logic hard_gate
);
  initial begin
    enc = '0;
    hard_gate = 1'b1;
  end
  // one count per cycle, never both directions at once
  task automatic pulse(input logic up, input int n);
    repeat (n) begin
      @(posedge clk);
      enc <= '{up: up, down: !up};
    end
    @(posedge clk);
    enc <= '0;
  endtask
  // low long enough to pass the synchroniser, then a fresh rising edge
  task automatic gate_edge();
    @(posedge clk);
    hard_gate <= 1'b0;
    repeat (5) @(posedge clk);
    hard_gate <= 1'b1;
  endtask
endmodule

// File: test/tb_counter_core.sv
// self-checking bench for the encoder counter core
`timescale 1ns/1ps
module tb_counter_core import counter_pkg::*;;
  logic clk;
  logic rst_n;
  bus_req_s bus_req;
  logic [DATA_W-1:0] rdata;
  enc_pulse_s enc;
  logic hard_gate;
  logic compare_out;
  logic overflow_flag;
  logic underflow_flag;
  logic gate_open;
  logic [31:0] count_value;
  event_s events;
  logic [31:0] d;
  int errors;
  int checks_done;
  counter_core #(.TICK_CYCLES(4)) DUT (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .enc(enc), .hard_gate(hard_gate), .compare_out(compare_out), .overflow_flag(overflow_flag),
    .underflow_flag(underflow_flag), .gate_open(gate_open), .count_value(count_value), .events(events));
  encoder_model u_enc (.clk(clk), .enc(enc), .hard_gate(hard_gate));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic wait_gate(input logic lvl);
    int n;
    n = 0;
    while (gate_open !== lvl && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (gate_open !== lvl) begin
      errors++;
      tally_and_finish();
    end
  endtask
  // commands act on a 0 to 1 change, so each is written low first
  task automatic gate(input logic op);
    wr(OFS_CMD, 32'h0);
    wr(OFS_CMD, op ? 32'h1 : 32'h2);
    wait_gate(op);
  endtask
  task automatic setup(input logic [31:0] c, input logic [31:0] l, input logic [31:0] e);
    wr(OFS_CTRL, c);
    wr(OFS_LOAD, l);
    wr(OFS_END, e);
  endtask
  task automatic go(input logic up, input int n);
    u_enc.pulse(up, n);
    @(negedge clk);
  endtask
  task automatic s_regs();
    chk(count_value, COUNT_RST);
    rd(8'h3c);
    chk(d, 32'h0);
    wr(OFS_HYST, 32'h1ff);
    rd(OFS_HYST);
    chk(d, 32'hff);
    wr(OFS_HYST, 32'h0);
    wr(OFS_PULSE, 32'hff);
    rd(OFS_PULSE);
    chk(d, 32'hff);
  endtask
  task automatic s_once(input logic [5:0] f, input logic [31:0] e, input logic up);
    setup({6'h01, 20'h0, f}, 32'h0, e);
    gate(1'b1);
    go(up, 2);
    chk(count_value, up ? 32'h2 : 32'hfffffffe);
    go(up, 1);
    chk(count_value, 32'h0);
    chk(32'(gate_open), 32'h0);
    go(up, 1);
    chk(count_value, 32'h0);
    gate(1'b1);
    go(up, 1);
    chk(count_value, up ? 32'h1 : 32'hffffffff);
    gate(1'b0);
  endtask
  task automatic s_endless();
    setup(32'h03000000, 32'h7ffffffe, 32'h0);
    gate(1'b1);
    chk(count_value, 32'h7ffffffe);
    go(1'b1, 2);
    @(negedge clk);
    chk(count_value, COUNT_MIN);
    chk(32'(overflow_flag), 32'h1);
    go(1'b0, 1);
    @(negedge clk);
    chk(count_value, COUNT_MAX);
    chk(32'(underflow_flag), 32'h1);
    wr(OFS_CMD, 32'h0);
    wr(OFS_CMD, 32'h4);
    repeat (3) @(negedge clk);
    chk({30'h0, overflow_flag, underflow_flag}, 32'h0);
    gate(1'b0);
  endtask
  task automatic s_gates();
    setup(32'h0, 32'ha, 32'h0);
    gate(1'b1);
    go(1'b1, 2);
    gate(1'b0);
    gate(1'b1);
    chk(count_value, 32'ha);
    wr(OFS_CTRL, 32'h200);
    go(1'b1, 2);
    gate(1'b0);
    gate(1'b1);
    chk(count_value, 32'hc);
    wr(OFS_CTRL, 32'h100);
    u_enc.gate_edge();
    wait_gate(1'b1);
    chk(count_value, 32'ha);
    go(1'b1, 1);
    gate(1'b0);
    gate(1'b1);
    chk(count_value, 32'hb);
    gate(1'b0);
  endtask
  task automatic s_compare();
    wr(OFS_PULSE, 32'h0);
    wr(OFS_HYST, 32'h0);
    wr(OFS_CMP, 32'h2);
    setup(32'h00010000, 32'h0, 32'h0);
    gate(1'b1);
    go(1'b1, 2);
    @(negedge clk);
    chk(32'(compare_out), 32'h1);
    go(1'b0, 1);
    @(negedge clk);
    chk(32'(compare_out), 32'h0);
    wr(OFS_HYST, 32'h3);
    go(1'b1, 1);
    go(1'b0, 1);
    @(negedge clk);
    chk(32'(compare_out), 32'h1);
    go(1'b0, 2);
    @(negedge clk);
    chk(32'(compare_out), 32'h0);
    wr(OFS_HYST, 32'h0);
    wr(OFS_PULSE, 32'h1);
    go(1'b1, 3);
    @(negedge clk);
    chk(32'(compare_out), 32'h1);
    repeat (6) @(negedge clk);
    chk(32'(compare_out), 32'h0);
    wr(OFS_PULSE, 32'h0);
    gate(1'b0);
  endtask
  task automatic s_flows();
    setup({26'h0, FCT_ONCE_NONE}, COUNT_MAX, 32'h0);
    gate(1'b1);
    go(1'b1, 1);
    chk(count_value, COUNT_MIN);
    chk(32'(gate_open), 32'h0);
    wr(OFS_CTRL, {22'h0, 1'b1, 3'h0, FCT_ONCE_NONE});
    gate(1'b1);
    chk(count_value, COUNT_MIN);
    gate(1'b0);
    setup({26'h0, FCT_PER_NONE}, 32'h7ffffffe, 32'h0);
    gate(1'b1);
    go(1'b1, 2);
    chk(count_value, 32'h7ffffffe);
    gate(1'b0);
  endtask
  initial begin
    errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    bus_req = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    s_regs();
    s_once(FCT_ONCE_FWD, 32'h3, 1'b1);
    s_once(FCT_ONCE_BWD, 32'hfffffffd, 1'b0);
    s_endless();
    s_gates();
    s_compare();
    s_flows();
    tally_and_finish();
  end
endmodule
bind counter_core counter_core_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk), .rst_n(rst_n),
  .bus_req(bus_req), .rdata(rdata), .enc(enc), .hard_gate(hard_gate), .compare_out(compare_out),
  .overflow_flag(overflow_flag), .underflow_flag(underflow_flag), .gate_open(gate_open),
  .count_value(count_value), .events(events));
